// File: logic/clk_switch_pkg.sv
// Constants, field layout and decode table of the system clock selection block.
package clk_switch_pkg;

  // ---------------------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------------------
  localparam int         DATA_W    = 8;
  localparam int         ADDR_W    = 2;
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_STAT = 2'h1;
  localparam logic [1:0] ADDR_T1   = 2'h2;

  localparam int CTRL_PLL_BIT   = 7;
  localparam int CTRL_IFS_LSB   = 3;
  localparam int CTRL_SCS_LSB   = 0;
  localparam int STAT_SEC_RDY   = 7;
  localparam int STAT_PLL_RDY   = 6;
  localparam int STAT_OST       = 5;
  localparam int STAT_HF_RDY    = 4;
  localparam int STAT_MF_RDY    = 3;
  localparam int STAT_LF_RDY    = 1;
  localparam int T1_OSC_EN_BIT  = 3;

  // ---------------------------------------------------------------------------
  // Field codes and reset values
  // ---------------------------------------------------------------------------
  localparam logic [3:0] IFS_RESET   = 4'h7;
  localparam logic [3:0] IFS_PLL     = 4'he;
  localparam logic [1:0] SCS_RESET   = 2'h0;
  localparam logic [1:0] SCS_DEFAULT = 2'h0;
  localparam logic [1:0] SCS_SEC     = 2'h1;
  localparam logic [2:0] MODE_INTERNAL_OSC_BLOCK = 3'h4;
  localparam logic [2:0] MODE_LP     = 3'h0;
  localparam logic [2:0] MODE_XT     = 3'h1;
  localparam logic [2:0] MODE_HS     = 3'h2;

  typedef enum logic [2:0] {SRC_LF, SRC_MF, SRC_HF, SRC_PLL, SRC_SEC, SRC_EXT} src_e;
  typedef logic [6:0] key_t;

  localparam int   POST_STAGES = 10;
  localparam key_t PLL_KEY     = {SRC_PLL, 4'h0};
  localparam key_t SEC_KEY     = {SRC_SEC, 4'h0};
  localparam key_t EXT_KEY     = {SRC_EXT, 4'h0};
  localparam key_t RESET_KEY   = {SRC_MF, 4'h0};
  localparam logic [2:0] RESET_OSC_ON = 3'h2;

  // Source and postscaler tap for each frequency select code.
  localparam key_t IFS_TABLE [0:15] = '{
    {SRC_LF, 4'h0}, {SRC_LF, 4'h0}, {SRC_MF, 4'h4}, {SRC_HF, 4'h9},
    {SRC_HF, 4'h8}, {SRC_HF, 4'h7}, {SRC_HF, 4'h6}, {SRC_MF, 4'h0},
    {SRC_MF, 4'h2}, {SRC_MF, 4'h1}, {SRC_HF, 4'h5}, {SRC_HF, 4'h4},
    {SRC_HF, 4'h3}, {SRC_HF, 4'h2}, {SRC_HF, 4'h1}, {SRC_HF, 4'h0}
  };

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int         CORE_CLK_PERIOD_NS  = 25;
  localparam int         INT_OSC_STARTUP_NS  = 2000;
  localparam int         STARTUP_CNT_W       = 7;
  localparam logic [6:0] INT_OSC_STARTUP_CYC =
    7'((INT_OSC_STARTUP_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS);
  localparam int         OST_CYCLES          = 1024;
  localparam logic [9:0] OST_LAST            = 10'(OST_CYCLES - 1);
  localparam logic [1:0] SYNC_EDGES          = 2'h2;

endpackage

// File: logic/postscale_if.sv
// Interface between an oscillator input and its postscaler.
`timescale 1ns/1ps
interface postscale_if;
  logic       osc_lvl;
  logic [9:0] stages;

  modport src    (output osc_lvl, input  stages);
  modport scaler (input  osc_lvl, output stages);
endinterface

// File: logic/clk_postscaler.sv
// Binary postscaler chain producing every divide-by-power-of-two tap of one oscillator.
`timescale 1ns/1ps
module clk_postscaler (
  input  logic          core_clk_i,
  input  logic          reset_i,
  postscale_if.scaler   ps
);

  logic [9:0] stage_q;
  logic [9:0] prev_q;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      stage_q[0] <= 1'b0;
      prev_q     <= 10'h000;
    end else begin
      stage_q[0] <= ps.osc_lvl;
      prev_q     <= stage_q;
    end
  end

  // Each stage toggles on a falling edge of the stage before it.
  genvar k;
  generate
    for (k = 1; k < clk_switch_pkg::POST_STAGES; k++) begin : g_stage
      logic fall;
      assign fall = prev_q[k-1] & ~stage_q[k-1];
      always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
          stage_q[k] <= 1'b0;
        end else if (fall) begin
          stage_q[k] <= ~stage_q[k];
        end
      end
    end
  endgenerate

  assign ps.stages = stage_q;

endmodule // clk_postscaler

// File: logic/system_clock_select_switch.sv
// System clock source selection with glitch-free switching and oscillator status.
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
module system_clock_select_switch (
  input  logic       core_clk_i,
  input  logic       reset_i,
  input  logic [1:0] reg_addr_i,
  input  logic [7:0] reg_wdata_i,
  input  logic       reg_wr_i,
  input  logic       reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input  logic [2:0] cfg_osc_mode_i,
  input  logic       cfg_pll_enable_i,
  input  logic       wdt_enable_i,
  input  logic       fail_safe_clock_monitor_enable_i,
  input  logic       hw_force_internal_i,
  input  logic       hf_osc_i,
  input  logic       mf_osc_i,
  input  logic       lf_osc_i,
  input  logic       pll_clk_i,
  input  logic       sec_osc_i,
  input  logic       sec_osc_ready_i,
  input  logic       ext_osc_i,
  output logic       hf_osc_en_o,
  output logic       mf_osc_en_o,
  output logic       lf_osc_en_o,
  output logic       pll_en_o,
  output logic       sec_osc_en_o,
  output logic       switch_busy_o,
  output logic       sys_clk_o
);

  typedef enum logic [2:0] {ST_IDLE, ST_STARTUP, ST_SYNC, ST_WAIT_FALL, ST_HOLD_LOW} state_e;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic clk_level(input clk_switch_pkg::key_t key,
                                     input logic [9:0] hf_st,
                                     input logic [9:0] mf_st,
                                     input logic lf, input logic pll,
                                     input logic sec, input logic ext);
    case (clk_switch_pkg::src_e'(key[6:4]))
      clk_switch_pkg::SRC_LF:  clk_level = lf;
      clk_switch_pkg::SRC_MF:  clk_level = mf_st[key[3:0]];
      clk_switch_pkg::SRC_HF:  clk_level = hf_st[key[3:0]];
      clk_switch_pkg::SRC_PLL: clk_level = pll;
      clk_switch_pkg::SRC_SEC: clk_level = sec;
      default:                 clk_level = ext;
    endcase
  endfunction

  // One-hot internal oscillator used by a source: bit 0 LF, 1 MF, 2 HF.
  function automatic logic [2:0] osc_of(input clk_switch_pkg::key_t key);
    case (clk_switch_pkg::src_e'(key[6:4]))
      clk_switch_pkg::SRC_LF:  osc_of = 3'h1;
      clk_switch_pkg::SRC_MF:  osc_of = 3'h2;
      clk_switch_pkg::SRC_HF:  osc_of = 3'h4;
      clk_switch_pkg::SRC_PLL: osc_of = 3'h4;
      default:                 osc_of = 3'h0;
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // Postscalers
  // ---------------------------------------------------------------------------
  postscale_if hf_ps ();
  postscale_if mf_ps ();

  assign hf_ps.osc_lvl = hf_osc_i;
  assign mf_ps.osc_lvl = mf_osc_i;

  clk_postscaler u_hf_post (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .ps         (hf_ps.scaler)
  );

  clk_postscaler u_mf_post (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .ps         (mf_ps.scaler)
  );

  // ---------------------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------------------
  logic [3:0] ifs_q;
  logic [1:0] scs_q;
  logic       spll_q;
  logic       sec_en_q;
  logic [7:0] rdata_q;
  logic       wr_ctrl;
  logic       wr_t1;
  logic [7:0] ctrl_rd;
  logic [7:0] stat_rd;
  logic [7:0] t1_rd;
  logic [7:0] rdata_d;

  assign wr_ctrl = reg_wr_i && (reg_addr_i == clk_switch_pkg::ADDR_CTRL);
  assign wr_t1   = reg_wr_i && (reg_addr_i == clk_switch_pkg::ADDR_T1);

  // Only a software write moves the source select; forced switches never touch it.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ifs_q  <= clk_switch_pkg::IFS_RESET;
      scs_q  <= clk_switch_pkg::SCS_RESET;
      spll_q <= 1'b0;
    end else if (wr_ctrl) begin
      ifs_q  <= reg_wdata_i[clk_switch_pkg::CTRL_IFS_LSB +: 4];
      scs_q  <= reg_wdata_i[clk_switch_pkg::CTRL_SCS_LSB +: 2];
      spll_q <= reg_wdata_i[clk_switch_pkg::CTRL_PLL_BIT];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sec_en_q <= 1'b0;
    end else if (wr_t1) begin
      sec_en_q <= reg_wdata_i[clk_switch_pkg::T1_OSC_EN_BIT];
    end
  end

  assign sec_osc_en_o = sec_en_q;

  // ---------------------------------------------------------------------------
  // Target source decode
  // ---------------------------------------------------------------------------
  clk_switch_pkg::key_t int_key;
  clk_switch_pkg::key_t dflt_key;
  clk_switch_pkg::key_t tgt_key;
  logic                 pll_on;
  logic                 pll_ok;
  logic                 crystal;
  logic                 ext_ok;
  logic                 ost_done_q;

  assign pll_on   = cfg_pll_enable_i | spll_q;
  assign pll_en_o = pll_on;
  assign int_key  = clk_switch_pkg::IFS_TABLE[ifs_q];
  assign crystal  = (cfg_osc_mode_i == clk_switch_pkg::MODE_LP) ||
                    (cfg_osc_mode_i == clk_switch_pkg::MODE_XT) ||
                    (cfg_osc_mode_i == clk_switch_pkg::MODE_HS);
  assign ext_ok   = ~crystal | ost_done_q;
  assign pll_ok   = (cfg_osc_mode_i == clk_switch_pkg::MODE_INTERNAL_OSC_BLOCK) &&
                    (scs_q == clk_switch_pkg::SCS_DEFAULT) &&
                    (ifs_q == clk_switch_pkg::IFS_PLL) && pll_on;
  assign dflt_key = (cfg_osc_mode_i == clk_switch_pkg::MODE_INTERNAL_OSC_BLOCK) ?
                    (pll_ok ? clk_switch_pkg::PLL_KEY : int_key) :
                    (ext_ok ? clk_switch_pkg::EXT_KEY : int_key);
  // Until the external crystal has settled the internal block keeps the core running.
  assign tgt_key  = hw_force_internal_i                ? int_key :
                    (scs_q == clk_switch_pkg::SCS_SEC) ? clk_switch_pkg::SEC_KEY :
                    scs_q[1]                           ? int_key : dflt_key;

  // ---------------------------------------------------------------------------
  // Start-up timer for crystal modes
  // ---------------------------------------------------------------------------
  logic [9:0] ost_cnt_q;
  logic       ext_prev_q;
  logic       ext_rise;

  assign ext_rise = ext_osc_i & ~ext_prev_q;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ost_cnt_q  <= 10'h000;
      ost_done_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_osc_i;
      if (crystal && !ost_done_q && ext_rise) begin
        ost_cnt_q  <= ost_cnt_q + 10'h001;
        ost_done_q <= (ost_cnt_q == clk_switch_pkg::OST_LAST);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Switch sequencer
  // ---------------------------------------------------------------------------
  state_e               state_q;
  state_e               state_d;
  clk_switch_pkg::key_t cur_key_q;
  clk_switch_pkg::key_t pend_key_q;
  logic [2:0]           osc_on_q;
  logic [2:0]           osc_on_d;
  logic [6:0]           wait_q;
  logic [1:0]           sync_q;
  logic                 new_lvl;
  logic                 old_lvl;
  logic                 new_prev_q;
  logic                 old_prev_q;
  logic                 new_rise;
  logic                 old_fall;
  logic                 start;
  logic                 need_startup;
  logic                 done;
  logic                 lf_keep;
  logic                 sys_clk_q;
  logic                 sys_clk_d;

  assign new_lvl      = clk_level(pend_key_q, hf_ps.stages, mf_ps.stages,
                                  lf_osc_i, pll_clk_i, sec_osc_i, ext_osc_i);
  assign old_lvl      = clk_level(cur_key_q, hf_ps.stages, mf_ps.stages,
                                  lf_osc_i, pll_clk_i, sec_osc_i, ext_osc_i);
  assign new_rise     = new_lvl & ~new_prev_q;
  assign old_fall     = old_prev_q & ~old_lvl;
  assign start        = (state_q == ST_IDLE) && (tgt_key != cur_key_q);
  assign need_startup = |(osc_of(tgt_key) & ~osc_on_q);
  assign done         = (state_q == ST_HOLD_LOW) && new_rise;
  assign lf_keep      = wdt_enable_i | fail_safe_clock_monitor_enable_i;
  // Old oscillators stop once the new one runs; the LF one stays while the watchdog or fail-safe clock monitor is enabled.
  assign osc_on_d     = osc_of(pend_key_q) | {2'h0, lf_keep};

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:      if (start) state_d = need_startup ? ST_STARTUP : ST_SYNC;
      ST_STARTUP:   if (wait_q == 7'h00) state_d = ST_SYNC;
      ST_SYNC:      if (new_rise && sync_q == 2'h1) state_d = ST_WAIT_FALL;
      ST_WAIT_FALL: if (old_fall) state_d = ST_HOLD_LOW;
      ST_HOLD_LOW:  if (new_rise) state_d = ST_IDLE;
      default:      state_d = ST_IDLE;
    endcase
  end

  // The held-low window cuts every runt pulse between the two clocks.
  assign sys_clk_d = (state_q == ST_HOLD_LOW) ? new_rise : old_lvl;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_q    <= ST_IDLE;
      new_prev_q <= 1'b0;
      old_prev_q <= 1'b0;
      sys_clk_q  <= 1'b0;
    end else begin
      state_q    <= state_d;
      new_prev_q <= new_lvl;
      old_prev_q <= old_lvl;
      sys_clk_q  <= sys_clk_d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pend_key_q <= clk_switch_pkg::RESET_KEY;
      wait_q     <= 7'h00;
      sync_q     <= 2'h0;
    end else if (start) begin
      pend_key_q <= tgt_key;
      wait_q     <= clk_switch_pkg::INT_OSC_STARTUP_CYC - 7'h01;
      sync_q     <= 2'h0;
    end else begin
      if (state_q == ST_STARTUP && wait_q != 7'h00) wait_q <= wait_q - 7'h01;
      if (state_q == ST_SYNC && new_rise) sync_q <= sync_q + 2'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cur_key_q <= clk_switch_pkg::RESET_KEY;
      osc_on_q  <= clk_switch_pkg::RESET_OSC_ON;
    end else if (done) begin
      cur_key_q <= pend_key_q;
      osc_on_q  <= osc_on_d;
    end
  end

  logic       switching;
  logic [2:0] pend_osc;
  assign switching     = (state_q != ST_IDLE);
  assign pend_osc      = osc_of(pend_key_q);
  assign hf_osc_en_o   = osc_on_q[2] | (switching & pend_osc[2]);
  assign mf_osc_en_o   = osc_on_q[1] | (switching & pend_osc[1]);
  assign lf_osc_en_o   = osc_on_q[0] | lf_keep | (switching & pend_osc[0]);
  assign switch_busy_o = switching;
  assign sys_clk_o     = sys_clk_q;

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  logic pll_ready;
  logic ost_status;

  assign pll_ready  = (cur_key_q[6:4] == clk_switch_pkg::SRC_PLL);
  assign ost_status = (cur_key_q[6:4] == clk_switch_pkg::SRC_EXT);
  assign ctrl_rd    = {spll_q, ifs_q, 1'b0, scs_q};
  assign stat_rd    = {sec_osc_ready_i, pll_ready, ost_status,
                       osc_on_q[2], osc_on_q[1], 1'b0, osc_on_q[0], 1'b0};
  assign t1_rd      = {4'h0, sec_en_q, 3'h0};
  assign rdata_d    = !reg_rd_i                                    ? 8'h00 :
                      (reg_addr_i == clk_switch_pkg::ADDR_CTRL)    ? ctrl_rd :
                      (reg_addr_i == clk_switch_pkg::ADDR_STAT)    ? stat_rd :
                      (reg_addr_i == clk_switch_pkg::ADDR_T1)      ? t1_rd : 8'h00;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) rdata_q <= 8'h00;
    else         rdata_q <= rdata_d;
  end

  assign reg_rdata_o = rdata_q;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking

  property p_reset_ifs;
    reset_i |=> (ifs_q == 4'h7) && (ctrl_rd[6:3] == 4'h7);
  endproperty
  a_reset_ifs: assert property (p_reset_ifs) else $error("select not 0111 after reset");

  property p_reset_scs;
    reset_i ##1 (!reg_wr_i) |-> (scs_q == 2'h0);
  endproperty
  a_reset_scs: assert property (p_reset_scs) else $error("source select not cleared");

  default disable iff (reset_i);

  property p_pll_only;
    (tgt_key[6:4] == clk_switch_pkg::SRC_PLL) |-> (cfg_osc_mode_i == 3'h4) &&
      (scs_q == 2'h0) && (ifs_q == 4'he) && (cfg_pll_enable_i || spll_q);
  endproperty
  a_pll_only: assert property (p_pll_only) else $error("PLL selected illegally");

  property p_scs_no_pll;
    scs_q[1] |-> (tgt_key[6:4] != clk_switch_pkg::SRC_PLL);
  endproperty
  a_scs_no_pll: assert property (p_scs_no_pll) else $error("PLL used with 1x source");

  property p_cfg_pll;
    cfg_pll_enable_i |-> pll_en_o;
  endproperty
  a_cfg_pll: assert property (p_cfg_pll) else $error("PLL off despite config enable");

  sequence s_old_fall;
    (state_q == ST_WAIT_FALL) && old_fall;
  endsequence
  sequence s_held_low;
    (state_q == ST_HOLD_LOW) && !new_rise;
  endsequence
  property p_hold_low;
    s_old_fall ##1 s_held_low |=> !sys_clk_o;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("clock not held low");

  property p_sync_two;
    (state_q == ST_SYNC) && new_rise && (sync_q == 2'h0) |=>
      (state_q == ST_SYNC) && (sync_q == 2'h1);
  endproperty
  a_sync_two: assert property (p_sync_two) else $error("sync left too early");

  property p_same_osc;
    start && ((osc_of(tgt_key) & ~osc_on_q) == 3'h0) |=> (state_q == ST_SYNC);
  endproperty
  a_same_osc: assert property (p_same_osc) else $error("needless start-up delay");

  property p_startup_len;
    start && need_startup |=> (state_q == ST_STARTUP) [*8];
  endproperty
  a_startup_len: assert property (p_startup_len) else $error("start-up cut short");

  property p_sec_en;
    wr_t1 |=> (sec_osc_en_o == $past(reg_wdata_i[3]));
  endproperty
  a_sec_en: assert property (p_sec_en) else $error("secondary enable not followed");

  property p_lf_keep;
    done && lf_keep |=> osc_on_q[0] && lf_osc_en_o;
  endproperty
  a_lf_keep: assert property (p_lf_keep) else $error("LF oscillator stopped");

  property p_pll_ready;
    done |=> (stat_rd[6] == (pend_key_q[6:4] == clk_switch_pkg::SRC_PLL));
  endproperty
  a_pll_ready: assert property (p_pll_ready) else $error("PLL ready wrong after switch");

  property p_force_scs;
    hw_force_internal_i && !wr_ctrl |=> $stable(scs_q);
  endproperty
  a_force_scs: assert property (p_force_scs) else $error("forced switch moved select");

endmodule // system_clock_select_switch

// File: test/test_system_clock_select_switch.sv
// Self-checking bench for the system clock selection and switching block.
`timescale 1ns/1ps
module test_system_clock_select_switch;
  logic       core_clk_i, reset_i, reg_wr_i, reg_rd_i, cfg_pll_enable_i, wdt_enable_i;
  logic       fail_safe_clock_monitor_enable_i, hw_force_internal_i, sec_osc_ready_i, hf_osc_i, mf_osc_i;
  logic       lf_osc_i, pll_clk_i, sec_osc_i, ext_osc_i, hf_osc_en_o, mf_osc_en_o;
  logic       lf_osc_en_o, pll_en_o, sec_osc_en_o, switch_busy_o, sys_clk_o;
  logic [1:0] reg_addr_i;
  logic [2:0] cfg_osc_mode_i;
  logic [3:0] ifs, f;
  logic [4:0] cyc;
  logic [7:0] reg_wdata_i, reg_rdata_o, d;
  int         n_mismatch, n_checks, n, k;

  system_clock_select_switch system_clock_select_switch_inst (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .cfg_osc_mode_i(cfg_osc_mode_i),
    .cfg_pll_enable_i(cfg_pll_enable_i), .wdt_enable_i(wdt_enable_i),
    .fail_safe_clock_monitor_enable_i(fail_safe_clock_monitor_enable_i), .hw_force_internal_i(hw_force_internal_i),
    .hf_osc_i(hf_osc_i), .mf_osc_i(mf_osc_i), .lf_osc_i(lf_osc_i), .pll_clk_i(pll_clk_i),
    .sec_osc_i(sec_osc_i), .sec_osc_ready_i(sec_osc_ready_i), .ext_osc_i(ext_osc_i),
    .hf_osc_en_o(hf_osc_en_o), .mf_osc_en_o(mf_osc_en_o), .lf_osc_en_o(lf_osc_en_o),
    .pll_en_o(pll_en_o), .sec_osc_en_o(sec_osc_en_o), .switch_busy_o(switch_busy_o),
    .sys_clk_o(sys_clk_o));

  // ---------------------------------------------------------------------------
  // Clock, oscillators and bus tasks
  // ---------------------------------------------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  // Oscillator levels toggle no faster than every two cycles, so the block can see them.
  always @(posedge core_clk_i) begin
    cyc       <= cyc + 5'h1;
    hf_osc_i  <= cyc[1];
    pll_clk_i <= cyc[1];
    ext_osc_i <= cyc[1];
    mf_osc_i  <= cyc[2];
    lf_osc_i  <= cyc[3];
    sec_osc_i <= cyc[4];
  end

  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge core_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    reg_wr_i    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  task rd(input logic [1:0] a);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  task wait_sw;
    #1 k = 0;
    while (switch_busy_o !== 1'b1 && k < 8) begin
      @(posedge core_clk_i);
      #1 k++;
    end
    n = 0;
    while (switch_busy_o === 1'b1 && n < 20000) begin
      @(posedge core_clk_i);
      #1 n++;
    end
    chk("switch_done", 8'h01, {7'h0, k < 8 && n < 20000});
  endtask

  task sw(input logic [7:0] v);
    wr(2'h0, v);
    wait_sw;
  endtask

  function logic [7:0] exp_st(input logic [3:0] c, input logic keep);
    logic [7:0] s;
    s = (c < 4'h2) ? 8'h02 : (c == 4'h2 || (c >= 4'h7 && c <= 4'h9)) ? 8'h08 : 8'h10;
    return s | (keep ? 8'h02 : 8'h00);
  endfunction

  task conclude;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #(95000 * 25);
    n_mismatch++;
    conclude;
  end

  initial begin
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, cyc} = '0;
    {hf_osc_i, mf_osc_i, lf_osc_i, pll_clk_i, sec_osc_i, ext_osc_i} = '0;
    {cfg_pll_enable_i, wdt_enable_i, fail_safe_clock_monitor_enable_i, hw_force_internal_i} = '0;
    sec_osc_ready_i = 1'b0;
    cfg_osc_mode_i  = 3'h4;
    reset_i         = 1'b1;
    void'($urandom(32'hc63a3c40));
    repeat (12) @(posedge core_clk_i);
    reset_i <= 1'b0;
    rd(2'h0); chk("ctrl_reset", 8'h38, d);
    rd(2'h1); chk("stat_reset", 8'h08, d);
    chk("en_reset", 8'h02, {5'h0, hf_osc_en_o, mf_osc_en_o, lf_osc_en_o});
    rd(2'h2); chk("t1_reset", 8'h00, d);
    rd(2'h3); chk("unmapped", 8'h00, d);
    wr(2'h2, 8'h08); chk("sec_en_on", 8'h01, {7'h0, sec_osc_en_o});
    wr(2'h2, 8'h00); chk("sec_en_off", 8'h00, {7'h0, sec_osc_en_o});
    $display("test reset and bus done");
    sw(8'h7a); chk("startup_wait", 8'h01, {7'h0, n >= 82});
    rd(2'h1); chk("stat_hf", 8'h10, d);
    sw(8'h6a); chk("same_source", 8'h01, {7'h0, n < 80});
    $display("test internal switch done");
    sw(8'hf0); chk("pll_en", 8'h01, {7'h0, pll_en_o});
    rd(2'h1); chk("pll_ready", 8'h50, d);
    sw(8'hf2); rd(2'h1); chk("pll_src_1x", 8'h10, d);
    cfg_pll_enable_i <= 1'b1;
    sw(8'h70); chk("cfg_pll_en", 8'h01, {7'h0, pll_en_o});
    rd(2'h1); chk("cfg_pll_ready", 8'h50, d);
    sw(8'h7a);
    cfg_pll_enable_i <= 1'b0;
    $display("test pll done");
    cfg_osc_mode_i <= 3'h1;
    sw(8'h38);
    d = 8'h00;
    for (int i = 0; i < 4000 && d[5] !== 1'b1; i++) rd(2'h1);
    chk("ext_status", 8'h20, d);
    @(posedge core_clk_i);
    hw_force_internal_i <= 1'b1;
    wait_sw;
    rd(2'h1); chk("forced_status", 8'h08, d);
    rd(2'h0); chk("forced_ctrl", 8'h38, d);
    @(posedge core_clk_i);
    hw_force_internal_i <= 1'b0;
    cfg_osc_mode_i      <= 3'h4;
    $display("test external done");
    sw(8'h02); rd(2'h1); chk("stat_lf", 8'h02, d);
    chk("en_lf", 8'h01, {5'h0, hf_osc_en_o, mf_osc_en_o, lf_osc_en_o});
    n = 0;
    repeat (40) begin
      @(posedge core_clk_i);
      #1 n += sys_clk_o;
    end
    chk("sys_clk_run", 8'h01, {7'h0, n > 0 && n < 40});
    sec_osc_ready_i <= 1'b1;
    wr(2'h2, 8'h08);
    rd(2'h1); chk("sec_ready", 8'h82, d);
    sw(8'h01); rd(2'h1); chk("stat_sec", 8'h80, d);
    sw(8'h02); rd(2'h1); chk("stat_back", 8'h82, d);
    ifs = 4'h0;
    repeat (6) begin
      f = 4'h2 + 4'($urandom % 14);
      if (f == ifs) f = (f == 4'hf) ? 4'h2 : f + 4'h1;
      @(posedge core_clk_i);
      wdt_enable_i    <= 1'($urandom % 2);
      fail_safe_clock_monitor_enable_i   <= 1'($urandom % 2);
      sec_osc_ready_i <= 1'($urandom % 2);
      sw({1'b0, f, 3'h2});
      rd(2'h1);
      chk("stat_rand", {sec_osc_ready_i, 7'h0} | exp_st(f, wdt_enable_i | fail_safe_clock_monitor_enable_i), d);
      ifs = f;
    end
    $display("test random select done");
    conclude;
  end
endmodule // test_system_clock_select_switch
